/* core/vof_top.sv */
// Video output formatter: strobe stream or embedded-code stream
//
// Summary of operation
// RULE1: One output format chosen by mode field
// RULE2: Eight-bit mode rounds, drives upper lines
// RULE3: Strobe mode outputs every pixel
// RULE4: Strobe mode drives separate timing outputs
// RULE5: Each strobe polarity chosen independently
// RULE6: Clock-invert bit inverts pixel clock
// RULE7: Pixel clock free, valid-gated, or valid-active-gated
// RULE8: Active is composite or horizontal only
// RULE9: Valid marks pixels or pixels AND active
// RULE10: Horizontal reset leads vertical by two; the code adds the two-cycle delay only while field_r is 0
// RULE11: Codes carry T F V H, change at EAV
// RULE12: Low nibble Hamming or zero per mode
// RULE13: Ten-bit codes get two zero LSBs
// RULE14: Task bit per mode and raw state
// RULE15: Field bit toggles at EAV after field end
// RULE16: V set at EAV after active end
// RULE17: V cleared after programmed half-line count
// RULE18: Align option uses the BT.656 delay
// RULE19: H zero in SAV, one in EAV
// RULE20: Clamp upper byte to 1..254
// RULE21: Blank fill in blanking, V lines
// RULE22: Ancillary packets in horizontal blanking
// RULE23: Packet header flags, DID, SDID, DC
// RULE24: Packets only when ancillary enabled
// RULE25: Data count as blocks or words
// RULE26: VIP identifiers programmable or line count
// RULE27: Raw samples replace blanked video
// RULE28: Order Cb Y Cr Y, flag marks Cb
// RULE29: Receiver samples per configured edge, polarity; vof_rx_model always captures on the falling edge of link_clk_in
//
// Decided for this implementation: the strobed register port.
`include "vof_defines.svh"
module vof_top
   import vof_pkg::*;
#(
   parameter int ANC_MAX = 16
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [11:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [9:0] luma_in,
   input wire logic [9:0] chroma_in,
   input wire logic [9:0] raw_in,
   input wire logic pix_valid_in,
   input wire logic h_active_in,
   input wire logic v_active_in,
   input wire logic h_reset_in,
   input wire logic v_reset_in,
   input wire logic field_end_in,
   input wire logic half_line_in,
   input wire logic anc_req_in,
   input wire logic [3:0] anc_type_in,
   input wire logic [4:0] anc_words_in,
   input wire logic [7:0] anc_word_in,
   input wire logic [7:0] slicer_line_in,
   output logic anc_word_take,
   input wire logic link_clk_in,
   output logic [9:0] video_data_bus,
   output logic pixel_clock_out,
   output logic vsync_out,
   output logic hsync_out,
   output logic vertical_active_strobe_out,
   output logic horizontal_active_strobe_out,
   output logic valid_out,
   output logic field_out,
   output logic chroma_blue_flag
);
   // ----------
   // Register file
   // ----------
   logic [7:0] ctl1_r, ctl2_r, ctl3_r, strobe_polarity_reg, idlo_r, idhi_r;
   logic [9:0] vdly_r;
   logic [7:0] v656_r;
   logic [7:0] rdata_r;
   logic field_r, vbit_r;
   wire vof_mode_t mode = vof_mode_t'(ctl1_r[`VOF_C1_MODE_LO +: 2]);
   wire ten_bit_output = ctl1_r[`VOF_C1_TENBIT];
   wire task_value = ctl1_r[`VOF_C1_TASK];
   wire raw_substitute_enable = ctl1_r[`VOF_C1_RAW];
   wire anc_enable = ctl1_r[`VOF_C1_ANC];
   wire [1:0] gate_sel = ctl2_r[`VOF_C2_GATE_LO +: 2];
   wire clk_invert = ctl2_r[`VOF_C2_INV];
   wire act_h_only = ctl2_r[`VOF_C2_ACTH];
   wire valid_format = ctl2_r[`VOF_C2_VALFMT];
   wire vip_align_option = ctl3_r[`VOF_C3_ALIGN];
   wire code_clamp_enable = ctl3_r[`VOF_C3_CLAMP];
   wire blank_fill_enable = ctl3_r[`VOF_C3_BLANK];
   wire data_count_mode = ctl3_r[`VOF_C3_DATA_COUNT_MODE];
   wire identifier_source = ctl3_r[`VOF_C3_IDSRC];
   wire is_spi = (mode == VOF_SPI);
   wire [7:0] status = {6'h00, vbit_r, field_r};
   wire [7:0] rd_mux =
      (reg_addr == `VOF_ADDR_CTL1) ? ctl1_r :
      (reg_addr == `VOF_ADDR_CTL2) ? ctl2_r :
      (reg_addr == `VOF_ADDR_CTL3) ? ctl3_r :
      (reg_addr == `VOF_ADDR_CTL4) ? strobe_polarity_reg :
      (reg_addr == `VOF_ADDR_IDLO) ? idlo_r :
      (reg_addr == `VOF_ADDR_IDHI) ? idhi_r :
      (reg_addr == `VOF_ADDR_VDLO) ? vdly_r[7:0] :
      (reg_addr == `VOF_ADDR_VDHI) ? {6'h00, vdly_r[9:8]} :
      (reg_addr == `VOF_ADDR_V656) ? v656_r :
      (reg_addr == `VOF_ADDR_STAT) ? status : 8'h00;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         ctl1_r <= `VOF_CTL_RST;
         ctl2_r <= `VOF_CTL_RST;
         ctl3_r <= `VOF_CTL_RST;
         strobe_polarity_reg <= `VOF_CTL_RST;
         idlo_r <= `VOF_CTL_RST;
         idhi_r <= `VOF_CTL_RST;
         vdly_r <= `VOF_VDLY_RST;
         v656_r <= `VOF_V656_RST;
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= reg_rd ? rd_mux : 8'h00;
         if (reg_wr) begin
            unique case (reg_addr)
               `VOF_ADDR_CTL1: ctl1_r <= reg_wdata;
               `VOF_ADDR_CTL2: ctl2_r <= reg_wdata;
               `VOF_ADDR_CTL3: ctl3_r <= reg_wdata;
               `VOF_ADDR_CTL4: strobe_polarity_reg <= reg_wdata;
               `VOF_ADDR_IDLO: idlo_r <= reg_wdata;
               `VOF_ADDR_IDHI: idhi_r <= reg_wdata;
               `VOF_ADDR_VDLO: vdly_r[7:0] <= reg_wdata;
               `VOF_ADDR_VDHI: vdly_r[9:8] <= reg_wdata[1:0];
               `VOF_ADDR_V656: v656_r <= reg_wdata;
               default: ;
            endcase
         end
      end
   end
   assign reg_rdata = rdata_r;

   // ----------
   // Link clock sampling and line timing
   // ----------
   logic lk_s1_r, lk_s2_r, lk_s3_r;
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         lk_s1_r <= 1'b0;
         lk_s2_r <= 1'b0;
         lk_s3_r <= 1'b0;
      end else begin
         lk_s1_r <= link_clk_in;
         lk_s2_r <= lk_s1_r;
         lk_s3_r <= lk_s2_r;
      end
   end
   // One pixel step per rising link edge
   wire pix_step = lk_s2_r & ~lk_s3_r;

   logic hact_d_r, field_pend_r, vend_pend_r;
   logic [9:0] hl_cnt_r;
   logic hrst_d1_r, hrst_d2_r;
   wire sav_ev = pix_step & h_active_in & ~hact_d_r;
   wire eav_ev = pix_step & ~h_active_in & hact_d_r;
   wire [9:0] vclr_lim = (is_spi | mode == VOF_BT656 | vip_align_option) ?
      {2'h0, v656_r} : vdly_r; // RULE17 RULE18
   wire vclr_now = vbit_r & (hl_cnt_r >= vclr_lim);
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hact_d_r <= 1'b0;
         field_r <= 1'b0;
         vbit_r <= 1'b1;
         field_pend_r <= 1'b0;
         vend_pend_r <= 1'b0;
         hl_cnt_r <= 10'h000;
      end else begin
         if (pix_step)
            hact_d_r <= h_active_in;
         // Set wins over clear for the pending flags
         field_pend_r <= field_end_in | (field_pend_r & ~eav_ev);
         vend_pend_r <= (pix_step & ~v_active_in) | (vend_pend_r & ~eav_ev);
         if (v_reset_in)
            hl_cnt_r <= 10'h000;
         else if (half_line_in && hl_cnt_r != 10'h3ff)
            hl_cnt_r <= hl_cnt_r + 10'h001;
         if (eav_ev) begin
            if (field_pend_r)
               field_r <= ~field_r; // RULE15
            if (vend_pend_r && !vbit_r && !v_active_in)
               vbit_r <= 1'b1; // RULE16
            else if (vclr_now)
               vbit_r <= 1'b0; // RULE17 RULE11
         end
      end
   end

   // ----------
   // Strobe path
   // ----------
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         hrst_d1_r <= 1'b0;
         hrst_d2_r <= 1'b0;
      end else begin
         hrst_d1_r <= v_reset_in;
         hrst_d2_r <= hrst_d1_r;
      end
   end
   // Vertical strobe trails horizontal by two cycles while field_r is 0
   wire vsync_raw = field_r ? v_reset_in : hrst_d2_r; // RULE10
   wire act_raw = act_h_only ? h_active_in : (h_active_in & v_active_in);
   wire val_raw = valid_format ? (pix_valid_in & act_raw) : pix_valid_in;
   logic cb_phase_r, cr_turn_r;
   // Active pin carries the configurable active indicator
   wire [6:0] strobes = {chroma_blue_flag_raw(cb_phase_r | cr_turn_r),
      field_r, val_raw, act_raw, v_active_in, h_reset_in, vsync_raw};
   function automatic logic chroma_blue_flag_raw(input logic ph);
      chroma_blue_flag_raw = ~ph;
   endfunction : chroma_blue_flag_raw
   logic [6:0] strobe_r;
   always_ff @(posedge clk_sys) begin
      if (rst)
         strobe_r <= 7'h00;
      else
         strobe_r <= strobes ^ strobe_polarity_reg[6:0]; // RULE4 RULE5 RULE8 RULE9
   end
   assign vsync_out = strobe_r[0];
   assign hsync_out = strobe_r[1];
   assign vertical_active_strobe_out = strobe_r[2];
   assign horizontal_active_strobe_out = strobe_r[3];
   assign valid_out = strobe_r[4];
   assign field_out = strobe_r[5];
   assign chroma_blue_flag = strobe_r[6];

   wire gate_on = (gate_sel == 2'h0) ? 1'b1 :
      (gate_sel == 2'h1) ? val_raw : (val_raw & act_raw); // RULE7
   logic pclk_r;
   always_ff @(posedge clk_sys) begin
      if (rst)
         pclk_r <= 1'b0;
      else
         pclk_r <= (lk_s2_r & gate_on) ^ clk_invert; // RULE6
   end
   assign pixel_clock_out = pclk_r;

   // ----------
   // Sample path
   // ----------
   // Cb Y Cr Y: even phase chroma, odd phase luma
   always_ff @(posedge clk_sys) begin
      if (rst | sav_ev | eav_ev) begin
         cb_phase_r <= 1'b0;
         cr_turn_r <= 1'b0;
      end else if (pix_step) begin
         cb_phase_r <= ~cb_phase_r; // RULE28
         if (cb_phase_r)
            cr_turn_r <= ~cr_turn_r;
      end
   end
   wire in_blank_h = ~h_active_in;
   wire raw_zone = raw_substitute_enable &
      (is_spi ? (~v_active_in & h_active_in) : (vbit_r & h_active_in));
   wire [9:0] samp = cb_phase_r ? luma_in : chroma_in; // RULE3
   wire blank_zone = blank_fill_enable & ~is_spi &
      (in_blank_h | (vbit_r & ~raw_substitute_enable)); // RULE21
   wire [9:0] fill = cb_phase_r ? `VOF_Y_BLANK : `VOF_C_BLANK;
   wire [9:0] pre = raw_zone ? raw_in : (blank_zone ? fill : samp); // RULE27
   // Rounding saturates at the top so 3ff does not wrap to zero
   wire [8:0] rnd_sum = {1'b0, pre[9:2]} + {8'h00, pre[1]};
   wire [7:0] rnd8 = rnd_sum[8] ? 8'hff : rnd_sum[7:0];
   wire [9:0] sized = ten_bit_output ? pre : {rnd8, 2'h0}; // RULE2
   wire [7:0] hi8 = sized[9:2];
   wire clamp_lo = code_clamp_enable & ~is_spi & (hi8 == 8'h00);
   wire clamp_hi = code_clamp_enable & ~is_spi & (hi8 == 8'hff);
   wire [9:0] clamped = clamp_lo ? {8'h01, sized[1:0]} :
      (clamp_hi ? {8'hfe, sized[1:0]} : sized); // RULE20

   // ----------
   // Control codes
   // ----------
   wire task_bit = (mode == VOF_BT656) ? 1'b1 :
      (mode == VOF_VIP2) ? task_value :
      ~(vbit_r & raw_substitute_enable); // RULE14
   function automatic logic [7:0] xy_code(input logic t, input logic f,
      input logic v, input logic h, input logic prot);
      logic [3:0] p;
      p = {v ^ h, f ^ h, f ^ v, f ^ v ^ h};
      xy_code = {t, f, v, h, prot ? p : 4'h0}; // RULE12
   endfunction : xy_code
   wire [7:0] eav_xy = xy_code(task_bit, field_r, vbit_r, 1'b1,
      mode == VOF_BT656); // RULE19
   wire [7:0] sav_xy = xy_code(task_bit, field_r, vbit_r, 1'b0,
      mode == VOF_BT656); // RULE19 RULE11

   // ----------
   // Sequencer: codes and ancillary packets
   // ----------
   vof_state_t st_r, st_nxt;
   logic [4:0] idx_r;
   logic is_eav_r, anc_done_r;
   wire vip = (mode == VOF_VIP11) | (mode == VOF_VIP2);
   wire [4:0] hdr_len = vip ? 5'd8 : 5'd6;
   wire [4:0] words_pad = {anc_words_in[4:2] + {2'h0, |anc_words_in[1:0]},
      2'h0};
   wire [4:0] pkt_len = hdr_len + (data_count_mode ? anc_words_in : words_pad);
   wire [7:0] dc_val = data_count_mode ? {3'h0, anc_words_in} :
      {5'h00, words_pad[4:2]}; // RULE25
   function automatic logic [7:0] par_byte(input logic [5:0] v);
      par_byte = {~(^v), ^v, v};
   endfunction : par_byte
   wire [7:0] id0 = identifier_source ? slicer_line_in : idlo_r; // RULE26
   wire [4:0] udw_idx = idx_r - hdr_len;
   wire udw_slot = idx_r >= hdr_len;
   wire udw_live = udw_slot & (udw_idx < anc_words_in);
   wire [7:0] anc_byte =
      (idx_r == 5'd0) ? 8'h00 :
      (idx_r == 5'd1) ? 8'hff :
      (idx_r == 5'd2) ? 8'hff :
      (idx_r == 5'd3) ? (vip ? 8'h91 : 8'h55) :
      (idx_r == 5'd4) ? par_byte({2'h0, anc_type_in}) :
      (idx_r == 5'd5) ? par_byte(dc_val[5:0]) :
      (!udw_slot && idx_r == 5'd6) ? id0 :
      (!udw_slot) ? idhi_r :
      (udw_live ? anc_word_in : 8'h00); // RULE23 RULE26
   wire [7:0] code_byte = (idx_r == 5'd0) ? 8'hff :
      (idx_r == 5'd3) ? (is_eav_r ? eav_xy : sav_xy) : 8'h00;
   wire start_anc = ~is_spi & anc_enable & anc_req_in & ~anc_done_r &
      in_blank_h; // RULE22 RULE24
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         VOF_ST_VIDEO:
            if (!is_spi && (sav_ev || eav_ev))
               st_nxt = VOF_ST_CODE;
            else if (pix_step && start_anc)
               st_nxt = VOF_ST_ANC;
         VOF_ST_CODE:
            if (pix_step && idx_r == 5'd3)
               st_nxt = VOF_ST_VIDEO;
         VOF_ST_ANC:
            if (pix_step && idx_r == pkt_len - 5'd1)
               st_nxt = VOF_ST_VIDEO;
         default: st_nxt = VOF_ST_VIDEO;
      endcase
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         st_r <= VOF_ST_VIDEO;
         idx_r <= 5'd0;
         is_eav_r <= 1'b0;
         anc_done_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         if (st_nxt != st_r)
            idx_r <= 5'd0;
         else if (pix_step)
            idx_r <= idx_r + 5'd1;
         if (eav_ev)
            is_eav_r <= 1'b1;
         else if (sav_ev)
            is_eav_r <= 1'b0;
         if (sav_ev)
            anc_done_r <= 1'b0;
         else if (st_r == VOF_ST_ANC && st_nxt == VOF_ST_VIDEO)
            anc_done_r <= 1'b1;
      end
   end
   assign anc_word_take = (st_r == VOF_ST_ANC) & pix_step & udw_live;

   // ----------
   // Output register
   // ----------
   wire [7:0] ctl_byte = (st_r == VOF_ST_CODE) ? code_byte : anc_byte;
   wire [9:0] out_sel = (st_r == VOF_ST_VIDEO) ? clamped :
      (ten_bit_output ? {ctl_byte, 2'h0} : {ctl_byte, 2'h0}); // RULE13 RULE1
   logic [9:0] vd_r;
   always_ff @(posedge clk_sys) begin
      if (rst)
         vd_r <= 10'h000;
      else if (pix_step)
         vd_r <= out_sel;
   end
   assign video_data_bus = vd_r;

   // ----------
   // Checks
   // ----------
   a_rd_lat: assert property (@(posedge clk_sys) disable iff (rst)
      reg_rd |=> reg_rdata == $past(rd_mux))
      else $error("read data wrong");
   a_clamp_range: assert property (@(posedge clk_sys) disable iff (rst)
      (st_r == VOF_ST_VIDEO && code_clamp_enable && !is_spi && pix_step) |=>
      (video_data_bus[9:2] != 8'h00 && video_data_bus[9:2] != 8'hff))
      else $error("clamp leak"); // RULE20
   a_eav_hbit: assert property (@(posedge clk_sys) disable iff (rst)
      eav_xy[4] && !sav_xy[4])
      else $error("H bit wrong"); // RULE19
   a_vip_low: assert property (@(posedge clk_sys) disable iff (rst)
      vip |-> eav_xy[3:0] == 4'h0)
      else $error("VIP low nibble"); // RULE12
   a_field_eav: assert property (@(posedge clk_sys) disable iff (rst)
      $changed(field_r) |-> $past(eav_ev))
      else $error("field moved off EAV"); // RULE15
   a_vbit_eav: assert property (@(posedge clk_sys) disable iff (rst)
      $changed(vbit_r) |-> $past(eav_ev))
      else $error("V moved off EAV"); // RULE11
   a_hv_gap: assert property (@(posedge clk_sys) disable iff (rst)
      (!field_r && $rose(v_reset_in)) |-> ##2 vsync_raw)
      else $error("vertical strobe gap"); // RULE10
   a_anc_gate: assert property (@(posedge clk_sys) disable iff (rst)
      (st_r == VOF_ST_VIDEO && st_nxt == VOF_ST_ANC) |-> anc_enable)
      else $error("packet without enable"); // RULE24
   a_bt_task: assert property (@(posedge clk_sys) disable iff (rst)
      mode == VOF_BT656 |-> task_bit)
      else $error("task bit"); // RULE14
   c_anc: cover property (@(posedge clk_sys) st_r == VOF_ST_ANC);
   c_code: cover property (@(posedge clk_sys) st_r == VOF_ST_CODE);
   c_field: cover property (@(posedge clk_sys) $changed(field_r));
   c_vclr: cover property (@(posedge clk_sys) $fell(vbit_r));
endmodule : vof_top

/* dv/vof_rx_model.sv */
// Capture-side model: samples the pixel stream and spots control codes
module vof_rx_model (
   input wire logic link_clk_in,
   input wire logic [9:0] video_data_bus
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [9:0] hist[$];
   logic [9:0] code_r;
   int n_code;
   int s;
   initial begin
      n_code = 0;
      code_r = '0;
   end
   // -----------------------------------------------
   // Capture
   // -----------------------------------------------
   // Mid-pixel capture, well clear of the update edge
   always @(negedge link_clk_in) begin
      hist.push_back(video_data_bus);
      if (hist.size() > 64) begin
         void'(hist.pop_front());
      end
      s = hist.size();
      if (s > 3 && hist[s-4][9:2] == 8'hff && hist[s-3][9:2] == 8'h00
          && hist[s-2][9:2] == 8'h00) begin
         code_r <= hist[s-1];
         n_code <= n_code + 1;
      end
   end
endmodule : vof_rx_model

/* dv/vof_top_tb.sv */
// Self-checking bench of the video output formatter
`include "vof_defines.svh"
module vof_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_sys, rst, link_clk_in, reg_wr, reg_rd, anc_req_in;
   logic [11:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, anc_word_in, slicer_line_in;
   logic pix_valid_in, h_active_in, v_active_in, h_reset_in, v_reset_in;
   logic field_end_in, half_line_in, anc_word_take, pixel_clock_out;
   logic [9:0] luma_in, chroma_in, raw_in, video_data_bus, sv, ev, md;
   logic [3:0] anc_type_in;
   logic [4:0] anc_words_in;
   logic vsync_out, hsync_out, vertical_active_strobe_out, horizontal_active_strobe_out, valid_out;
   logic field_out, chroma_blue_flag, pa, pb;
   int n_fail, checks;

   vof_top u_dut (.*);
   vof_rx_model m (.*);

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // Odd offset keeps the pixel clock unrelated in phase
   initial begin
      link_clk_in = 1'b0;
      #7;
      forever #40 link_clk_in = ~link_clk_in;
   end
   always @(posedge clk_sys) begin
      if (anc_word_take === 1'b1) begin
         anc_word_in <= anc_word_in + 8'h01;
      end
   end
   // -----------------------------------------------
   // Helpers
   // -----------------------------------------------
   task automatic chk(input logic [9:0] g, input logic [9:0] e);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rdc(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      #1;
      chk({2'b00, reg_rdata}, {2'b00, e});
   endtask : rdc
   task automatic pix(input int n);
      repeat (n) @(negedge link_clk_in);
   endtask : pix
   task automatic ph;
      @(posedge link_clk_in);
      #24;
      pa = pixel_clock_out;
      @(negedge link_clk_in);
      #24;
      pb = pixel_clock_out;
   endtask : ph
   task automatic get_code(output logic [9:0] c);
      int c0;
      c0 = m.n_code;
      for (int i = 0; i < 30 && m.n_code == c0; i++) begin
         @(negedge link_clk_in);
         #1;
      end
      if (m.n_code == c0) begin
         n_fail++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, c0, c0 + 1);
         end_sim();
      end
      c = m.code_r;
   endtask : get_code
   // One video line: SAV, active samples, EAV, blanking
   task automatic line(input bit fe);
      @(posedge clk_sys) h_active_in <= 1'b1;
      get_code(sv);
      pix(3);
      md = video_data_bus;
      if (fe) begin
         @(posedge clk_sys) field_end_in <= 1'b1;
         @(posedge clk_sys) field_end_in <= 1'b0;
      end
      pix(3);
      @(posedge clk_sys) h_active_in <= 1'b0;
      get_code(ev);
      pix(24);
   endtask : line
   function automatic logic [9:0] xy(input logic t, f, v, h, bt);
      xy = {t, f, v, h, bt ? {v ^ h, f ^ h, f ^ v, f ^ v ^ h} : 4'h0, 2'b00};
   endfunction : xy
   function automatic logic [9:0] anw(input logic [5:0] b);
      anw = {~(^b), ^b, b, 2'b00};
   endfunction : anw
   function automatic int find_pkt();
      for (int i = 0; i + 7 < m.hist.size(); i++) begin
         if (m.hist[i][9:2] == 8'h00 && m.hist[i+1][9:2] == 8'hff
             && m.hist[i+2][9:2] == 8'hff) return i;
      end
      return -1;
   endfunction : find_pkt
   task automatic end_sim;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   // -----------------------------------------------
   // Scenarios
   // -----------------------------------------------
   task automatic t_regs;
      rdc(`VOF_ADDR_CTL1, `VOF_CTL_RST);
      rdc(`VOF_ADDR_CTL4, `VOF_CTL_RST);
      rdc(`VOF_ADDR_VDLO, 8'(`VOF_VDLY_RST));
      rdc(`VOF_ADDR_V656, `VOF_V656_RST);
      wr(`VOF_ADDR_CTL3, 8'h1f);
      wr(12'h400, 8'h5a);
      rdc(`VOF_ADDR_CTL3, 8'h1f);
      rdc(12'h400, 8'h00);
      wr(`VOF_ADDR_CTL3, 8'h00);
      $display("t_regs done");
   endtask : t_regs
   task automatic t_spi;
      int k;
      k = 0;
      pix(3);
      chk(video_data_bus, 10'h200);
      wr(`VOF_ADDR_CTL1, 8'h04);
      pix(3);
      chk(video_data_bus, 10'h1fe);
      repeat (8) begin
         pix(1);
         if (chroma_blue_flag === 1'b1) k++;
      end
      chk(10'(k), 10'h002);
      $display("t_spi done");
   endtask : t_spi
   task automatic t_strb;
      @(posedge clk_sys) h_active_in <= 1'b1;
      pix(3);
      chk(horizontal_active_strobe_out, 10'h0);
      chk({vertical_active_strobe_out, hsync_out, vsync_out}, 10'h0);
      chk(valid_out, 10'h1);
      wr(`VOF_ADDR_CTL2, 8'h18);
      pix(3);
      chk({horizontal_active_strobe_out, valid_out}, 10'h3);
      wr(`VOF_ADDR_CTL2, 8'h10);
      pix(3);
      chk(valid_out, 10'h0);
      wr(`VOF_ADDR_CTL4, 8'h08);
      pix(3);
      chk({vertical_active_strobe_out, horizontal_active_strobe_out}, 10'h1);
      wr(`VOF_ADDR_CTL4, 8'h00);
      wr(`VOF_ADDR_CTL2, 8'h00);
      $display("t_strb done");
   endtask : t_strb
   task automatic t_clk;
      ph();
      chk({pa, pb}, 10'h2);
      wr(`VOF_ADDR_CTL2, 8'h04);
      pix(2);
      ph();
      chk({pa, pb}, 10'h1);
      wr(`VOF_ADDR_CTL2, 8'h01);
      @(posedge clk_sys) pix_valid_in <= 1'b0;
      pix(3);
      ph();
      chk(pa, pb);
      @(posedge clk_sys) pix_valid_in <= 1'b1;
      pix(3);
      ph();
      chk({pa, pb}, 10'h2);
      wr(`VOF_ADDR_CTL2, 8'h02);
      pix(3);
      ph();
      chk(pa, pb);
      wr(`VOF_ADDR_CTL2, 8'h0a);
      pix(3);
      ph();
      chk({pa, pb}, 10'h2);
      wr(`VOF_ADDR_CTL2, 8'h00);
      @(posedge clk_sys) h_active_in <= 1'b0;
      $display("t_clk done");
   endtask : t_clk
   task automatic t_hv;
      int n;
      n = 0;
      @(posedge clk_sys);
      h_reset_in <= 1'b1;
      v_reset_in <= 1'b1;
      for (int i = 0; i < 40 && hsync_out !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      while (vsync_out !== 1'b1 && n < 40) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk(10'(n), 10'(`VOF_HV_GAP));
      @(posedge clk_sys);
      h_reset_in <= 1'b0;
      v_reset_in <= 1'b0;
      $display("t_hv done");
   endtask : t_hv
   task automatic t_codes;
      logic [7:0] tab [6];
      logic [7:0] c;
      logic t;
      tab = '{8'h01, 8'h02, 8'h12, 8'h03, 8'h0b, 8'h05};
      foreach (tab[i]) begin
         c = tab[i];
         wr(`VOF_ADDR_CTL1, c);
         pix(4);
         line(1'b0);
         t = (c[1:0] == 2'h1) ? 1'b1 : (c[1:0] == 2'h3) ? c[3] : !c[4];
         chk(sv, xy(t, 1'b0, 1'b1, 1'b0, c[1:0] == 2'h1));
         chk(ev, xy(t, 1'b0, 1'b1, 1'b1, c[1:0] == 2'h1));
         if (c[4]) chk(md, 10'h154);
      end
      $display("t_codes done");
   endtask : t_codes
   task automatic t_clamp;
      wr(`VOF_ADDR_CTL1, 8'h01);
      wr(`VOF_ADDR_CTL3, 8'h02);
      @(posedge clk_sys) luma_in <= 10'h3ff;
      @(posedge clk_sys) chroma_in <= 10'h3ff;
      line(1'b0);
      chk(md, 10'h3f8);
      @(posedge clk_sys) luma_in <= 10'h000;
      @(posedge clk_sys) chroma_in <= 10'h000;
      line(1'b0);
      chk(md, 10'h004);
      wr(`VOF_ADDR_CTL3, 8'h04);
      line(1'b0);
      chk(md === 10'h040 ? 10'h200 : md, 10'h200);
      chk(video_data_bus === 10'h040 ? 10'h200 : video_data_bus,
          10'h200);
      wr(`VOF_ADDR_CTL3, 8'h00);
      @(posedge clk_sys) luma_in <= 10'h1fe;
      @(posedge clk_sys) chroma_in <= 10'h1fe;
      $display("t_clamp done");
   endtask : t_clamp
   task automatic t_anc;
      int k;
      wr(`VOF_ADDR_CTL3, 8'h08);
      wr(`VOF_ADDR_CTL1, 8'h21);
      // Raised with active so no packet can slip in before SAV
      @(posedge clk_sys) {anc_req_in, h_active_in} <= 2'b11;
      m.hist.delete();
      line(1'b0);
      k = find_pkt();
      chk(10'(k < 0), 10'h0);
      chk(m.hist[k+3], {8'h55, 2'b00});
      chk(m.hist[k+4], anw(6'h03));
      chk(m.hist[k+5], anw(6'h02));
      chk(m.hist[k+6], {8'h10, 2'b00});
      chk(m.hist[k+7], {8'h11, 2'b00});
      wr(`VOF_ADDR_CTL1, 8'h01);
      m.hist.delete();
      line(1'b0);
      chk(10'(find_pkt() + 1), 10'h000);
      @(posedge clk_sys) anc_req_in <= 1'b0;
      wr(`VOF_ADDR_CTL3, 8'h00);
      $display("t_anc done");
   endtask : t_anc
   task automatic t_field;
      wr(`VOF_ADDR_V656, 8'h02);
      line(1'b1);
      chk(sv, xy(1'b1, 1'b0, 1'b1, 1'b0, 1'b1));
      chk(ev, xy(1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
      @(posedge clk_sys) v_active_in <= 1'b1;
      @(posedge clk_sys) v_reset_in <= 1'b1;
      @(posedge clk_sys) v_reset_in <= 1'b0;
      repeat (2) begin
         @(posedge clk_sys) half_line_in <= 1'b1;
         @(posedge clk_sys) half_line_in <= 1'b0;
      end
      line(1'b0);
      chk(sv, xy(1'b1, 1'b1, 1'b1, 1'b0, 1'b1));
      chk(ev, xy(1'b1, 1'b1, 1'b0, 1'b1, 1'b1));
      @(posedge clk_sys) v_active_in <= 1'b0;
      line(1'b0);
      chk(ev, xy(1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
      $display("t_field done");
   endtask : t_field
   // -----------------------------------------------
   // Main sequence
   // -----------------------------------------------
   initial begin
      n_fail = 0;
      checks = 0;
      rst = 1'b1;
      {reg_wr, reg_rd, anc_req_in, h_active_in, v_active_in} = '0;
      {h_reset_in, v_reset_in, field_end_in, half_line_in} = '0;
      pix_valid_in = 1'b1;
      reg_addr = '0;
      reg_wdata = '0;
      luma_in = 10'h1fe;
      chroma_in = 10'h1fe;
      raw_in = 10'h155;
      anc_word_in = 8'h10;
      slicer_line_in = 8'h07;
      anc_type_in = 4'h3;
      anc_words_in = 5'h02;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      t_regs();
      t_spi();
      t_strb();
      t_clk();
      t_hv();
      t_codes();
      t_clamp();
      t_anc();
      t_field();
      end_sim();
   end
endmodule : vof_top_tb

/* inc/vof_defines.svh */
// Register offsets, field positions and reset values of the output formatter
`ifndef VOF_DEFINES_SVH
`define VOF_DEFINES_SVH
`define VOF_ADDR_CTL1 12'h404
`define VOF_ADDR_CTL2 12'h405
`define VOF_ADDR_CTL3 12'h406
`define VOF_ADDR_CTL4 12'h407
`define VOF_ADDR_IDLO 12'h408
`define VOF_ADDR_IDHI 12'h409
`define VOF_ADDR_VDLO 12'h474
`define VOF_ADDR_VDHI 12'h475
`define VOF_ADDR_V656 12'h477
`define VOF_ADDR_STAT 12'h478
// Control 1 fields
`define VOF_C1_MODE_LO 0
`define VOF_C1_TENBIT 2
`define VOF_C1_TASK 3
`define VOF_C1_RAW 4
`define VOF_C1_ANC 5
// Control 2 fields
`define VOF_C2_GATE_LO 0
`define VOF_C2_INV 2
`define VOF_C2_ACTH 3
`define VOF_C2_VALFMT 4
// Control 3 fields
`define VOF_C3_ALIGN 0
`define VOF_C3_CLAMP 1
`define VOF_C3_BLANK 2
`define VOF_C3_DATA_COUNT_MODE 3
`define VOF_C3_IDSRC 4
`define VOF_CTL_RST 8'h00
`define VOF_VDLY_RST 10'h014
`define VOF_V656_RST 8'h14
`define VOF_Y_BLANK 10'h040
`define VOF_C_BLANK 10'h200
`define VOF_HV_GAP 2
`endif

/* inc/vof_pkg.sv */
// Types of the output formatter
package vof_pkg;
   typedef enum logic [1:0] {
      VOF_SPI = 2'h0,
      VOF_BT656 = 2'h1,
      VOF_VIP11 = 2'h2,
      VOF_VIP2 = 2'h3
   } vof_mode_t;
   typedef enum logic [1:0] {
      VOF_ST_VIDEO = 2'h0,
      VOF_ST_CODE = 2'h1,
      VOF_ST_ANC = 2'h2
   } vof_state_t;
endpackage : vof_pkg
